/* File: core/lcs_core.sv */
// link-core deep-sleep wake controller and diagnostic pin driver
// assumes low_power_clock is a slow level sampled here via a synchroniser;
// all control bits are plain ports driven by software logic; status bits are plain ports read by it
// ==========================================
// How it works
// [R1] software enables link clocks and powers the domain before wake
// [R2] after expiry the timer waits in sleep until domain is up
// [R3] status reports actual sleep length including late power-up cycles
// [R4] expired, clocked and powered: leave sleep and pulse sleep exit irq
// [R5] writing wake request forces early wake; wake irq rises at once
// [R6] external wake irq high span is the external wake field less the deassert offset
// [R7] while wake request is high, deep sleep entry is refused
// [R8] external wake disable makes the device ignore wake requests for early wake; they still refuse sleep entry
// [R9] software may delay wake request until crystal trim ready
// [R10] eight diagnostic outputs each carry a selected internal signal
// [R11] ports zero to seven map to P2_0 P2_1 P2_2 P1_0 P1_1 P1_2 P1_3 P2_3
// [R12] two select registers choose among documented signal schemes
// [R13] event scheme: txen rxen window found active end rx error
// [R14] sync window is high while correlating against access address
// [R15] sync found pulses only on successful correlation
// [R16] event active stays high while a radio event is processed
// [R17] event end irq pulses at every advertising scanning connection end
// [R18] error irq pulses on simultaneous link core and processor access
// [R19] data scheme: rx then tx data with qualifiers, packet then bitstream
// [R20] bitstream data comes from the engine doing check code and whitening
// [R21] wake irq rises programmed low-power cycles before timer expiry
// [R22] wake irq falls programmed low-power cycles before sleep end
// [R23] software programs timing, then duration, then sleep-on bit
// [R24] software polls power-down allowed before gating core clocks
// [R25] diagnostic outputs are registered copies of selected signals
// [R26] timer counts low-power cycles; wake requests synchronised to clk
`timescale 1ns/100ps
module lcs_core
  import lcs_pkg::*;
#(
  parameter int TW = LCS_TIME_W,
  parameter int OW = LCS_OFS_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic low_power_clock,
  // sleep control from software
  input wire logic deep_sleep_on,
  input wire logic [TW-1:0] programmed_sleep_time,
  input wire logic [OW-1:0] wake_irq_assert_offset,
  input wire logic [OW-1:0] wake_irq_deassert_offset,
  input wire logic [OW-1:0] external_wake_high_span,
  input wire logic external_wake_disable,
  input wire logic wake_request,
  input wire logic radio_clock_enable,
  input wire logic link_domain_up_flag,
  output logic [TW-1:0] actual_sleep_status_reg,
  output logic radio_powerdown_allowed,
  output logic in_deep_sleep,
  output logic low_power_wake_irq,
  output logic sleep_exit_irq,
  // internal link-core signals
  input wire logic radio_tx_enable,
  input wire logic radio_rx_enable,
  input wire logic correlating,
  input wire logic correlation_ok,
  input wire logic event_start,
  input wire logic event_done,
  input wire logic rx_packet_irq,
  input wire logic link_mem_access,
  input wire logic cpu_mem_access,
  input wire logic pkt_rx_data,
  input wire logic pkt_rx_data_en,
  input wire logic bs_rx_data,
  input wire logic bs_rx_data_en,
  input wire logic pkt_tx_data,
  input wire logic pkt_tx_data_en,
  input wire logic bs_tx_data,
  input wire logic bs_tx_data_en,
  input wire logic [31:0] diag_select_reg_a,
  input wire logic [31:0] diag_select_reg_b,
  input wire logic [31:0] diag_port_order_reg,
  output logic pin_p2_0,
  output logic pin_p2_1,
  output logic pin_p2_2,
  output logic pin_p1_0,
  output logic pin_p1_1,
  output logic pin_p1_2,
  output logic pin_p1_3,
  output logic pin_p2_3
);
  // ==========================================
  // state
  typedef struct packed {
    lcs_state_t fsm;
    logic lp_prev;
    logic [TW-1:0] elapsed;
    logic [TW-1:0] sleep_time;
    logic wake_irq;
    logic [OW-1:0] ext_cnt;
    logic ext_active;
    logic exit_irq;
    logic evt_active;
  } lcs_core_t;
  lcs_core_t st_q, st_d;

  logic lp_sync;
  logic wreq_sync;
  logic lp_tick;
  logic wake_req_eff;
  logic [TW-1:0] remain;
  logic expired;

  lcs_sync u_sync_lp (
    .clk(clk),
    .rst(rst),
    .din(low_power_clock),
    .dout(lp_sync)
  );
  lcs_sync u_sync_wreq (
    .clk(clk),
    .rst(rst),
    .din(wake_request),
    .dout(wreq_sync) // [R26]
  );

  assign lp_tick = lp_sync & ~st_q.lp_prev; // [R26]
  assign wake_req_eff = wreq_sync & ~external_wake_disable; // [R8]
  assign expired = (st_q.elapsed >= st_q.sleep_time);
  assign remain = expired ? '0 : st_q.sleep_time - st_q.elapsed;

  // ==========================================
  // sleep timer and wake interrupts
  always_comb begin
    st_d = st_q;
    st_d.lp_prev = lp_sync;
    st_d.exit_irq = 1'b0;
    case (st_q.fsm)
      LCS_ST_ACTIVE: begin
        st_d.wake_irq = 1'b0;
        if (deep_sleep_on && !wreq_sync) begin // [R7]
          st_d.fsm = LCS_ST_SLEEP;
          st_d.elapsed = '0;
          st_d.sleep_time = programmed_sleep_time;
        end
      end
      LCS_ST_SLEEP: begin
        if (lp_tick) begin
          st_d.elapsed = st_q.elapsed + 1'b1; // [R26]
        end
        if (wake_req_eff && !st_q.ext_active) begin
          // early wake: cut sleep time to elapsed, raise irq at once
          st_d.wake_irq = 1'b1; // [R5]
          st_d.ext_active = 1'b1;
          st_d.ext_cnt = external_wake_high_span - wake_irq_deassert_offset; // [R6]
          st_d.sleep_time = st_q.elapsed;
        end else if (st_q.ext_active) begin
          if (lp_tick) begin
            if (st_q.ext_cnt <= 1) begin
              st_d.wake_irq = 1'b0; // [R6]
            end else begin
              st_d.ext_cnt = st_q.ext_cnt - 1'b1;
            end
          end
        end else begin
          if (remain <= TW'(wake_irq_assert_offset) && remain > TW'(wake_irq_deassert_offset)) begin
            st_d.wake_irq = 1'b1; // [R21]
          end else begin
            st_d.wake_irq = 1'b0; // [R22]
          end
        end
        if (expired && !st_d.wake_irq) begin
          st_d.fsm = LCS_ST_WAIT_UP;
        end
      end
      LCS_ST_WAIT_UP: begin
        st_d.wake_irq = 1'b0;
        if (link_domain_up_flag && radio_clock_enable) begin // [R2]
          st_d.fsm = LCS_ST_EXIT;
        end else if (lp_tick) begin
          st_d.elapsed = st_q.elapsed + 1'b1; // [R3]
        end
      end
      LCS_ST_EXIT: begin
        st_d.exit_irq = 1'b1; // [R4]
        st_d.ext_active = 1'b0;
        st_d.fsm = LCS_ST_ACTIVE;
      end
      default: st_d.fsm = LCS_ST_ACTIVE;
    endcase
  end

  // ==========================================
  // event envelope
  logic [LCS_NUM_DIAG-1:0] evt_set;
  logic [LCS_NUM_DIAG-1:0] dat_set;
  logic evt_active_d;
  always_comb begin
    evt_active_d = st_q.evt_active;
    if (event_start) begin
      evt_active_d = 1'b1; // [R16]
    end else if (event_done) begin
      evt_active_d = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q.fsm <= LCS_ST_ACTIVE;
      st_q.lp_prev <= 1'b0;
      st_q.elapsed <= '0;
      st_q.sleep_time <= '0;
      st_q.wake_irq <= 1'b0;
      st_q.ext_cnt <= '0;
      st_q.ext_active <= 1'b0;
      st_q.exit_irq <= 1'b0;
      st_q.evt_active <= 1'b0;
    end else begin
      st_q <= st_d;
      st_q.evt_active <= evt_active_d;
    end
  end

  assign evt_set = {
    link_mem_access & cpu_mem_access, // [R18]
    rx_packet_irq,
    event_done, // [R17]
    st_q.evt_active,
    correlating & correlation_ok, // [R15]
    correlating, // [R14]
    radio_rx_enable,
    radio_tx_enable
  };
  assign dat_set = {
    bs_tx_data_en, bs_tx_data, pkt_tx_data_en, pkt_tx_data, // [R20]
    bs_rx_data_en, bs_rx_data, pkt_rx_data_en, pkt_rx_data
  };

  logic [LCS_NUM_DIAG-1:0] diag;
  lcs_diag_mux #(
    .NUM(LCS_NUM_DIAG)
  ) u_mux (
    .clk(clk),
    .rst(rst),
    .diag_select_reg_a(diag_select_reg_a),
    .diag_select_reg_b(diag_select_reg_b),
    .diag_port_order_reg(diag_port_order_reg),
    .event_set(evt_set),
    .data_set(dat_set),
    .diag_out(diag)
  );

  // ==========================================
  // outputs
  assign pin_p2_0 = diag[0]; // [R11]
  assign pin_p2_1 = diag[1];
  assign pin_p2_2 = diag[2];
  assign pin_p1_0 = diag[3];
  assign pin_p1_1 = diag[4];
  assign pin_p1_2 = diag[5];
  assign pin_p1_3 = diag[6];
  assign pin_p2_3 = diag[7];
  assign actual_sleep_status_reg = st_q.elapsed; // [R3]
  assign in_deep_sleep = (st_q.fsm != LCS_ST_ACTIVE);
  assign radio_powerdown_allowed = (st_q.fsm == LCS_ST_SLEEP);
  assign low_power_wake_irq = st_q.wake_irq;
  assign sleep_exit_irq = st_q.exit_irq;
endmodule : lcs_core

/* File: core/lcs_diag_mux.sv */
// diagnostic multiplexer: picks one of the signal schemes and reorders
// onto the eight pins; outputs are registered
// assumes internal signals are synchronous to clk
`timescale 1ns/100ps
module lcs_diag_mux
  import lcs_pkg::*;
#(
  parameter int NUM = LCS_NUM_DIAG
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [31:0] diag_select_reg_a,
  input wire logic [31:0] diag_select_reg_b,
  input wire logic [31:0] diag_port_order_reg,
  input wire logic [NUM-1:0] event_set,
  input wire logic [NUM-1:0] data_set,
  output logic [NUM-1:0] diag_out
);
  typedef struct packed {
    logic [NUM-1:0] pins;
  } lcs_mux_t;
  lcs_mux_t st_q, st_d;
  lcs_scheme_t scheme;
  logic [NUM-1:0] src;
  always_comb begin
    if (diag_select_reg_a == LCS_SEL_EVENT && diag_select_reg_b == LCS_SEL_EVENT) begin
      scheme = LCS_SCHEME_EVENT; // [R12]
    end else if (diag_select_reg_a == LCS_SEL_DATA && diag_select_reg_b == LCS_SEL_DATA) begin
      scheme = LCS_SCHEME_DATA;
    end else begin
      scheme = LCS_SCHEME_OFF;
    end
    case (scheme)
      LCS_SCHEME_EVENT: src = event_set; // [R13]
      LCS_SCHEME_DATA: src = data_set; // [R19]
      default: src = '0;
    endcase
    // the low three bits of each nibble of the order register name the source for that port
    for (int i = 0; i < NUM; i++) begin
      st_d.pins[i] = src[diag_port_order_reg[i*4 +: 3]]; // [R10]
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d; // [R25]
    end
  end
  assign diag_out = st_q.pins;
endmodule : lcs_diag_mux

/* File: core/lcs_pkg.sv */
// package for the link-core sleep/wake controller and diagnostic multiplexer
// assumes a single 250 MHz clock with synchronous active-high reset
package lcs_pkg;
  localparam int LCS_TIME_W = 32;
  localparam int LCS_OFS_W = 10;
  localparam int LCS_NUM_DIAG = 8;
  // diag select values recognised by the multiplexer, and the standard port order
  localparam logic [31:0] LCS_SEL_EVENT = 32'h83838383;
  localparam logic [31:0] LCS_SEL_DATA = 32'h92929292;
  localparam logic [31:0] LCS_ORDER_STD = 32'h76543210;
  // reset values and synchroniser depth
  localparam logic [31:0] LCS_SEL_RST = 32'h00000000;
  localparam logic [2:0] LCS_SYNC_STAGES = 3'h2;
  typedef enum logic [3:0] {
    LCS_ST_ACTIVE = 4'b0001,
    LCS_ST_SLEEP = 4'b0010,
    LCS_ST_WAIT_UP = 4'b0100,
    LCS_ST_EXIT = 4'b1000
  } lcs_state_t;
  typedef enum logic [1:0] {
    LCS_SCHEME_OFF = 2'h0,
    LCS_SCHEME_EVENT = 2'h1,
    LCS_SCHEME_DATA = 2'h2
  } lcs_scheme_t;
endpackage : lcs_pkg

/* File: core/lcs_sync.sv */
// two-stage level synchroniser into the clk domain
// assumes the input is an asynchronous level from another domain
`timescale 1ns/100ps
module lcs_sync
  import lcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  typedef struct packed {
    logic s1;
    logic s2;
  } lcs_sync_t;
  lcs_sync_t st_q, st_d;
  always_comb begin
    st_d.s1 = din;
    st_d.s2 = st_q.s1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign dout = st_q.s2;
endmodule : lcs_sync

/* File: verif/lcs_core_sva.sv */
// port checks for lcs_core
// assumes a bind onto lcs_core; one clock, rst synchronous high
`timescale 1ns/100ps
module lcs_core_chk
  import lcs_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic wake_request,
  input wire logic external_wake_disable,
  input wire logic link_domain_up_flag,
  input wire logic radio_powerdown_allowed,
  input wire logic in_deep_sleep,
  input wire logic low_power_wake_irq,
  input wire logic sleep_exit_irq,
  input wire logic radio_tx_enable,
  input wire logic correlating,
  input wire logic correlation_ok,
  input wire logic link_mem_access,
  input wire logic cpu_mem_access,
  input wire logic bs_rx_data_en,
  input wire logic [31:0] diag_select_reg_a,
  input wire logic [31:0] diag_select_reg_b,
  input wire logic [31:0] diag_port_order_reg,
  input wire logic pin_p2_0,
  input wire logic pin_p1_0,
  input wire logic pin_p2_3
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire logic ord_std = diag_port_order_reg == LCS_ORDER_STD;
  wire logic ev = diag_select_reg_a == LCS_SEL_EVENT && diag_select_reg_b == LCS_SEL_EVENT && ord_std;
  wire logic dt = diag_select_reg_a == LCS_SEL_DATA && diag_select_reg_b == LCS_SEL_DATA && ord_std;
  sequence s_ev;
    !$past(rst) && $past(ev);
  endsequence
  sequence s_wake_req;
    radio_powerdown_allowed && !external_wake_disable && $rose(wake_request);
  endsequence
  // ==========================================
  // diagnostic pins and sleep control
  a_diag_txen: assert property (s_ev |-> pin_p2_0 == $past(radio_tx_enable))
    else $error("tx enable pin mismatch");
  a_sync_found: assert property (s_ev |-> pin_p1_0 == $past(correlating && correlation_ok))
    else $error("sync found pin mismatch");
  a_error_irq: assert property (s_ev |-> pin_p2_3 == $past(link_mem_access && cpu_mem_access))
    else $error("error irq pin mismatch");
  a_data_bitstream: assert property (!$past(rst) && $past(dt) |-> pin_p1_0 == $past(bs_rx_data_en))
    else $error("bit stream qualifier pin mismatch");
  a_entry_refused: assert property (!in_deep_sleep && !external_wake_disable && wake_request[*3] |=> !in_deep_sleep)
    else $error("sleep entered under wake request");
  a_wake_fast: assert property (s_wake_req |-> ##[1:4] low_power_wake_irq)
    else $error("wake irq late");
  a_exit_pulse: assert property (sleep_exit_irq |=> !sleep_exit_irq)
    else $error("sleep exit irq too long");
  a_wait_domain: assert property (!link_domain_up_flag[*2] |=> !sleep_exit_irq)
    else $error("exit while domain down");
endmodule : lcs_core_chk

/* File: verif/lcs_far_model.sv */
// far side: free low-power clock, link clocks and power domain
// assumes power_req from the bench stands for software powering up
`timescale 1ns/100ps
module lcs_far_model (
  input wire logic clk,
  input wire logic power_req,
  input wire logic radio_powerdown_allowed,
  output logic low_power_clock,
  output logic radio_clock_enable,
  output logic link_domain_up_flag
);
  int up_cnt = 0;
  initial low_power_clock = 1'b0;
  initial radio_clock_enable = 1'b1;
  initial link_domain_up_flag = 1'b1;
  always #40 low_power_clock = ~low_power_clock;
  // domain comes up slowly, well after the clocks, so the exit runs late
  always @(negedge clk) begin
    if (power_req) begin
      radio_clock_enable <= 1'b1;
      up_cnt <= up_cnt + 1;
      if (up_cnt >= 400) link_domain_up_flag <= 1'b1;
    end else if (radio_powerdown_allowed) begin
      radio_clock_enable <= 1'b0;
      link_domain_up_flag <= 1'b0;
      up_cnt <= 0;
    end
  end
endmodule : lcs_far_model

/* File: verif/testbench.sv */
// bench for lcs_core: diag schemes, sleep entry, timed and forced exit
// assumes lcs_far_model plays the low-power clock and power domain
`timescale 1ns/100ps
module testbench;
  import lcs_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic power_req = 1'b0;
  logic deep_sleep_on = 1'b0;
  logic wake_request = 1'b0;
  logic external_wake_disable = 1'b0;
  logic [LCS_TIME_W-1:0] programmed_sleep_time = 32'h8;
  logic [LCS_OFS_W-1:0] wake_irq_assert_offset = 10'h3;
  logic [LCS_OFS_W-1:0] wake_irq_deassert_offset = 10'h1;
  logic [LCS_OFS_W-1:0] external_wake_high_span = 10'h4;
  logic [31:0] diag_select_reg_a = LCS_SEL_EVENT;
  logic [31:0] diag_select_reg_b = LCS_SEL_EVENT;
  logic [31:0] diag_port_order_reg = LCS_ORDER_STD;
  logic [16:0] src = 17'h0;
  logic [LCS_TIME_W-1:0] actual_sleep_status_reg;
  logic low_power_clock, radio_clock_enable, link_domain_up_flag, radio_powerdown_allowed;
  logic in_deep_sleep, low_power_wake_irq, sleep_exit_irq;
  logic [7:0] pins;
  int fail_count = 0;
  int total_checks = 0;
  int n;
  always #2 clk = ~clk;
  lcs_far_model lcs_far_model_inst (.*);
  lcs_core lcs_core_inst (.*, .radio_tx_enable(src[0]), .radio_rx_enable(src[1]),
    .correlating(src[2]), .correlation_ok(src[3]), .event_start(src[4]), .event_done(src[5]),
    .rx_packet_irq(src[6]), .link_mem_access(src[7]), .cpu_mem_access(src[8]),
    .pkt_rx_data(src[9]), .pkt_rx_data_en(src[10]), .bs_rx_data(src[11]),
    .bs_rx_data_en(src[12]), .pkt_tx_data(src[13]), .pkt_tx_data_en(src[14]),
    .bs_tx_data(src[15]), .bs_tx_data_en(src[16]), .pin_p2_0(pins[0]), .pin_p2_1(pins[1]),
    .pin_p2_2(pins[2]), .pin_p1_0(pins[3]), .pin_p1_1(pins[4]), .pin_p1_2(pins[5]),
    .pin_p1_3(pins[6]), .pin_p2_3(pins[7]));
  // ==========================================
  // tasks
  task end_of_test();
    if (fail_count == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : end_of_test
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // bounded wait: 0 sleep state, 1 wake irq, 2 sleep exit irq
  task wt(input int sel, input logic v);
    for (n = 0; n < 3000; n++) begin
      @(negedge clk);
      if ((sel == 0 ? in_deep_sleep : sel == 1 ? low_power_wake_irq : sleep_exit_irq) === v) break;
    end
    if (n == 3000) begin
      fail_count++;
      end_of_test();
    end
  endtask : wt
  task drive(input logic [16:0] s);
    @(negedge clk);
    src = s;
    @(negedge clk);
  endtask : drive
  task sleep_go(input logic [31:0] t);
    @(negedge clk);
    power_req = 1'b0;
    programmed_sleep_time = t;
    @(negedge clk);
    deep_sleep_on = 1'b1;
    wt(0, 1'b1);
    deep_sleep_on = 1'b0;
  endtask : sleep_go
  // ==========================================
  // main sequence
  initial begin
    int i;
    logic [16:0] s;
    logic [7:0] e;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    check(32'(pins), 32'h0);
    for (i = 0; i < 11; i++) begin
      s = (i < 9) ? 17'h1 << i : (i == 9) ? 17'h0c : 17'h180;
      drive(s);
      check(32'(pins & 8'hef), 32'({s[7] & s[8], s[6:5], 1'b0, s[2] & s[3], s[2:0]}));
    end
    drive(17'h10);
    drive(17'h0);
    check(32'(pins[4]), 32'h1);
    drive(17'h20);
    drive(17'h0);
    check(32'(pins[4]), 32'h0);
    diag_select_reg_a = LCS_SEL_DATA;
    diag_select_reg_b = LCS_SEL_DATA;
    for (i = 0; i < 16; i++) begin
      if (i == 8) diag_port_order_reg = 32'h01234567;
      s = 17'h200 << (i % 8);
      drive(s);
      e = s[16:9];
      if (i >= 8) e = {<<{e}};
      check(32'(pins), 32'(e));
    end
    diag_port_order_reg = LCS_ORDER_STD;
    diag_select_reg_b = LCS_SEL_EVENT;
    drive(17'h1ffff);
    check(32'(pins), 32'h0);
    sleep_go(32'h8);
    wt(1, 1'b1);
    power_req = 1'b1;
    wt(2, 1'b1);
    check(32'(actual_sleep_status_reg > 32'h8), 32'h1);
    check(32'(low_power_wake_irq), 32'h0);
    wake_request = 1'b1;
    repeat (4) @(negedge clk);
    deep_sleep_on = 1'b1;
    repeat (20) @(negedge clk);
    check(32'(in_deep_sleep), 32'h0);
    deep_sleep_on = 1'b0;
    wake_request = 1'b0;
    sleep_go(32'h400);
    // software raises the wake request as early as it may, ahead of trim ready
    wake_request = 1'b1;
    repeat (4) @(negedge clk);
    check(32'(low_power_wake_irq), 32'h1);
    wt(1, 1'b0);
    check(32'(n > 34 && n < 64), 32'h1);
    power_req = 1'b1;
    wt(2, 1'b1);
    check(32'(link_domain_up_flag && radio_clock_enable), 32'h1);
    wake_request = 1'b0;
    external_wake_disable = 1'b1;
    sleep_go(32'h400);
    wake_request = 1'b1;
    repeat (30) @(negedge clk);
    check(32'({low_power_wake_irq, in_deep_sleep}), 32'h1);
    end_of_test();
  end
endmodule : testbench
bind lcs_core lcs_core_chk lcs_core_chk_inst (.*);
